// ### rtl/p2p_acr_pkg.sv
`default_nettype none

package p2p_acr_pkg;

   // Sizes of the function set and of the register port.
   localparam int FN_CNT = 8;
   localparam int FN_W   = 3;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // Register word addresses.
   localparam logic [7:0] CTRL_BASE  = 8'h00;
   localparam logic [7:0] EGR_BASE   = 8'h08;
   localparam logic [7:0] GRP_BASE   = 8'h10;
   localparam logic [7:0] GLOBAL_OFS = 8'h18;
   localparam logic [7:0] STATUS_OFS = 8'h19;
   localparam logic [7:0] MASK_OFS   = 8'h1A;
   localparam logic [7:0] VIOL_OFS   = 8'h1B;

   // Per-function control word fields.
   localparam int CTRL_W     = 4;
   localparam int CB_REQ_RDR = 0;
   localparam int CB_CPL_RDR = 1;
   localparam int CB_DIRECT  = 2;
   localparam int CB_EGR_EN  = 3;

   // Global register field.
   localparam int GB_GRP_EN = 0;

   // Status and mask fields.
   localparam int ST_W      = 3;
   localparam int ST_VIOL   = 0;
   localparam int ST_REQ_UP = 1;
   localparam int ST_CPL_UP = 2;

   // Address type code of a translated address.
   localparam logic [1:0] AT_TRANSLATED = 2'h2;

   // Routing decision, one-hot.
   typedef enum logic [2:0] {
      ROUTE_DIRECT   = 3'h1,
      ROUTE_UPSTREAM = 3'h2,
      ROUTE_BLOCKED  = 3'h4
   } route_t;

   // Packet kind.
   typedef enum logic [1:0] {
      KIND_MEM_REQ   = 2'h0,
      KIND_OTHER_REQ = 2'h1,
      KIND_RD_CPL    = 2'h2,
      KIND_OTHER_CPL = 2'h3
   } kind_t;

   // Header fields that steer routing, and a tag carried along.
   typedef struct packed {
      kind_t       kind;    // Request or completion kind.
      logic [1:0]  at;      // Address type.
      logic        relaxed; // Relaxed ordering attribute.
      logic [2:0]  src;     // Sending function.
      logic [2:0]  dst;     // Target function.
      logic [15:0] tag;     // Carried through untouched.
   } pkt_t;

   // Register port request.
   typedef struct packed {
      logic        wr;    // Write strobe.
      logic        rd;    // Read strobe.
      logic [7:0]  addr;  // Word address.
      logic [31:0] wdata; // Write data.
   } bus_req_t;

endpackage : p2p_acr_pkg

`default_nettype wire

// ### rtl/p2p_access_control_router.sv
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module p2p_access_control_router #(
   parameter bit MULTI_FUNCTION = 1'b1, // Device has several functions.
   parameter bit SRIOV_CAPABLE  = 1'b0, // Device supports virtual functions.
   parameter bit IS_DSP         = 1'b0, // Function is a downstream port.
   parameter bit HAS_ATS        = 1'b1, // Function supports translation.
   parameter bit HAS_EGRESS     = 1'b1  // Egress control is built.
) (
   input  wire logic                  clk,        // Link-layer clock.
   input  wire logic                  rst_n,      // Asynchronous reset.
   input  wire p2p_acr_pkg::bus_req_t bus,        // Register port request.
   output var  logic [31:0]           rd_data,    // Read data, one cycle later.
   input  wire logic                  in_valid,   // Peer packet present.
   input  wire p2p_acr_pkg::pkt_t     in_pkt,     // Peer packet header.
   output var  logic                  out_valid,  // Decision present.
   output var  p2p_acr_pkg::pkt_t     out_pkt,    // Header of the decided packet.
   output var  p2p_acr_pkg::route_t   out_route,  // Routing decision.
   output var  logic                  viol_pulse, // Violation reported.
   output var  logic                  irq         // Interrupt level.
);

   // Access control exists only where the device is shared among functions.
   // scope of controls
   localparam bit ACS_ON = (MULTI_FUNCTION || SRIOV_CAPABLE) && !IS_DSP;

   // All state of the block.
   typedef struct packed {
      logic [7:0][3:0]          ctrl;      // Per-function control words.
      logic [7:0][7:0]          egr;       // Per-function blocked target sets.
      logic [7:0][2:0]          grp;       // Group number of each function.
      logic                     grp_en;    // Function groups in force.
      logic [2:0]               status;    // Sticky event bits.
      logic [2:0]               mask;      // Interrupt enables.
      logic [5:0]               viol_info; // Last blocked sender and target.
      logic [31:0]              rd_data;   // Read data register.
      logic                     out_valid; // Decision valid.
      p2p_acr_pkg::pkt_t        out_pkt;   // Decided header.
      p2p_acr_pkg::route_t      out_route; // Decision.
      logic                     viol;      // Violation pulse.
      logic                     irq;       // Interrupt level.
   } state_t;

   state_t st;      // Registered state.
   state_t next_st; // Next state.

   // Tells whether a register address falls in a per-function bank.
   function automatic logic in_bank(input logic [7:0] a, input logic [7:0] base);
      in_bank = (a >= base) && (a < base + 8'(p2p_acr_pkg::FN_CNT));
   endfunction : in_bank

   // Picks the function index out of a bank address.
   function automatic logic [2:0] bank_idx(input logic [7:0] a);
      bank_idx = a[p2p_acr_pkg::FN_W-1:0];
   endfunction : bank_idx

   // Tells whether the packet is a completion.
   function automatic logic is_cpl(input p2p_acr_pkg::pkt_t p);
      is_cpl = (p.kind == p2p_acr_pkg::KIND_RD_CPL) ||
               (p.kind == p2p_acr_pkg::KIND_OTHER_CPL);
   endfunction : is_cpl

   // Tells whether the packet is a translated memory request.
   function automatic logic is_xlat(input p2p_acr_pkg::pkt_t p);
      is_xlat = (p.kind == p2p_acr_pkg::KIND_MEM_REQ) &&
                (p.at == p2p_acr_pkg::AT_TRANSLATED);
   endfunction : is_xlat

   // Tells whether the sender's egress set blocks the target.
   function automatic logic egr_hit(input state_t s, input p2p_acr_pkg::pkt_t p);
      logic [2:0] t;
      t = p.dst;
      if (s.grp_en)
      begin
         t = s.grp[p.dst];
      end
      egr_hit = s.egr[p.src][t];
   endfunction : egr_hit

   // Routes one packet with the controls of its sender.
   function automatic p2p_acr_pkg::route_t decide(input state_t s,
                                                   input p2p_acr_pkg::pkt_t p);
      logic [3:0] c;
      c = s.ctrl[p.src];
      decide = p2p_acr_pkg::ROUTE_DIRECT;
      if (!ACS_ON || (p.src == p.dst))
      begin
         // Not a peer transfer or no controls: route normally.
         decide = p2p_acr_pkg::ROUTE_DIRECT;
      end
      else if (is_cpl(p))
      begin
         // completions see only their own control
         if (c[p2p_acr_pkg::CB_CPL_RDR] && (p.kind == p2p_acr_pkg::KIND_RD_CPL) &&
             !p.relaxed)
         begin
            decide = p2p_acr_pkg::ROUTE_UPSTREAM;
         end
      end
      else if (c[p2p_acr_pkg::CB_DIRECT] && is_xlat(p))
      begin
         decide = p2p_acr_pkg::ROUTE_DIRECT;
      end
      else if (c[p2p_acr_pkg::CB_EGR_EN] && egr_hit(s, p))
      begin
         decide = p2p_acr_pkg::ROUTE_BLOCKED;
      end
      else if (c[p2p_acr_pkg::CB_REQ_RDR])
      begin
         decide = p2p_acr_pkg::ROUTE_UPSTREAM;
      end
   endfunction : decide

   // Register writes, routing, events and read data.
   always_comb
   begin
      logic [2:0]          set;   // Events this cycle.
      logic [2:0]          clr;   // Bits software clears.
      logic [2:0]          idx;   // Bank index of the access.
      logic [3:0]          wmask; // Writable control bits.
      p2p_acr_pkg::route_t r;     // Decision this cycle.
      set     = '0;
      clr     = '0;
      idx     = bank_idx(bus.addr);
      r       = decide(st, in_pkt);
      next_st = st;
      // only redirect, egress and direct bits exist
      wmask   = '0;
      wmask[p2p_acr_pkg::CB_REQ_RDR] = ACS_ON;
      wmask[p2p_acr_pkg::CB_CPL_RDR] = ACS_ON;
      wmask[p2p_acr_pkg::CB_DIRECT]  = ACS_ON && HAS_ATS;
      wmask[p2p_acr_pkg::CB_EGR_EN]  = ACS_ON && HAS_EGRESS;

      // Register writes; unmapped addresses are ignored.
      if (bus.wr)
      begin
         if (in_bank(bus.addr, p2p_acr_pkg::CTRL_BASE))
         begin
            next_st.ctrl[idx] = bus.wdata[3:0] & wmask;
         end
         else if (in_bank(bus.addr, p2p_acr_pkg::EGR_BASE))
         begin
            if (ACS_ON && HAS_EGRESS)
            begin
               next_st.egr[idx] = bus.wdata[7:0];
            end
         end
         else if (in_bank(bus.addr, p2p_acr_pkg::GRP_BASE))
         begin
            if (ACS_ON && HAS_EGRESS)
            begin
               next_st.grp[idx] = bus.wdata[2:0];
            end
         end
         else if (bus.addr == p2p_acr_pkg::GLOBAL_OFS)
         begin
            next_st.grp_en = bus.wdata[p2p_acr_pkg::GB_GRP_EN] && ACS_ON && HAS_EGRESS;
         end
         else if (bus.addr == p2p_acr_pkg::STATUS_OFS)
         begin
            clr = bus.wdata[2:0];
         end
         else if (bus.addr == p2p_acr_pkg::MASK_OFS)
         begin
            next_st.mask = bus.wdata[2:0];
         end
      end

      // One decision per packet, one cycle later.
      next_st.out_valid = in_valid;
      next_st.out_pkt   = in_valid ? in_pkt : st.out_pkt;
      next_st.out_route = in_valid ? r : p2p_acr_pkg::ROUTE_DIRECT;
      next_st.viol      = in_valid && (r == p2p_acr_pkg::ROUTE_BLOCKED);
      if (in_valid)
      begin
         if (r == p2p_acr_pkg::ROUTE_BLOCKED)
         begin
            set[p2p_acr_pkg::ST_VIOL] = 1'b1;
            next_st.viol_info = {in_pkt.src, in_pkt.dst};
         end
         else if (r == p2p_acr_pkg::ROUTE_UPSTREAM)
         begin
            if (is_cpl(in_pkt))
            begin
               set[p2p_acr_pkg::ST_CPL_UP] = 1'b1;
            end
            else
            begin
               set[p2p_acr_pkg::ST_REQ_UP] = 1'b1;
            end
         end
      end

      // A new event wins over a clear in the same cycle.
      next_st.status = (st.status & ~clr) | set;
      next_st.irq    = |(next_st.status & next_st.mask);

      // Read data stand for one cycle only; unmapped reads give zero.
      next_st.rd_data = '0;
      if (bus.rd)
      begin
         if (in_bank(bus.addr, p2p_acr_pkg::CTRL_BASE))
         begin
            next_st.rd_data[3:0] = st.ctrl[idx];
         end
         else if (in_bank(bus.addr, p2p_acr_pkg::EGR_BASE))
         begin
            next_st.rd_data[7:0] = st.egr[idx];
         end
         else if (in_bank(bus.addr, p2p_acr_pkg::GRP_BASE))
         begin
            next_st.rd_data[2:0] = st.grp[idx];
         end
         else if (bus.addr == p2p_acr_pkg::GLOBAL_OFS)
         begin
            next_st.rd_data[p2p_acr_pkg::GB_GRP_EN] = st.grp_en;
         end
         else if (bus.addr == p2p_acr_pkg::STATUS_OFS)
         begin
            next_st.rd_data[2:0] = st.status;
         end
         else if (bus.addr == p2p_acr_pkg::MASK_OFS)
         begin
            next_st.rd_data[2:0] = st.mask;
         end
         else if (bus.addr == p2p_acr_pkg::VIOL_OFS)
         begin
            next_st.rd_data[5:0] = st.viol_info;
         end
      end
   end

   // State register.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st           <= '0;
         st.out_route <= p2p_acr_pkg::ROUTE_DIRECT;
      end
      else
      begin
         st <= next_st;
      end
   end

   // Outputs straight from the state register.
   assign rd_data    = st.rd_data;
   assign out_valid  = st.out_valid;
   assign out_pkt    = st.out_pkt;
   assign out_route  = st.out_route;
   assign viol_pulse = st.viol;
   assign irq        = st.irq;

   // Checks on the routing decisions, the interrupt and the read data.
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   // Sender's controls as seen on the input side.
   logic [3:0] in_ctrl; // Control word of the current sender.
   assign in_ctrl = st.ctrl[in_pkt.src];

   a_cpl_redirect_up: assert property (
      in_valid && ACS_ON && (in_pkt.src != in_pkt.dst) &&
      (in_pkt.kind == p2p_acr_pkg::KIND_RD_CPL) && !in_pkt.relaxed &&
      in_ctrl[p2p_acr_pkg::CB_CPL_RDR]
      |=> out_valid && (out_route == p2p_acr_pkg::ROUTE_UPSTREAM))
      else $error("Strict read completion was not redirected.");

   a_cpl_never_blocked: assert property (
      out_valid && is_cpl(out_pkt) |-> out_route != p2p_acr_pkg::ROUTE_BLOCKED)
      else $error("Completion was blocked.");

   a_cpl_ignores_req: assert property (
      in_valid && is_cpl(in_pkt) && !in_ctrl[p2p_acr_pkg::CB_CPL_RDR]
      |=> out_route == p2p_acr_pkg::ROUTE_DIRECT)
      else $error("Completion rerouted by a request control.");

   a_req_redirect_up: assert property (
      in_valid && ACS_ON && (in_pkt.src != in_pkt.dst) && !is_cpl(in_pkt) &&
      !is_xlat(in_pkt) && !in_ctrl[p2p_acr_pkg::CB_EGR_EN] &&
      in_ctrl[p2p_acr_pkg::CB_REQ_RDR]
      |=> out_route == p2p_acr_pkg::ROUTE_UPSTREAM)
      else $error("Peer request was not redirected.");

   a_req_ignores_cpl: assert property (
      in_valid && !is_cpl(in_pkt) && !in_ctrl[p2p_acr_pkg::CB_REQ_RDR] &&
      !in_ctrl[p2p_acr_pkg::CB_EGR_EN]
      |=> out_route == p2p_acr_pkg::ROUTE_DIRECT)
      else $error("Request rerouted by the completion control.");

   a_xlat_goes_direct: assert property (
      in_valid && is_xlat(in_pkt) && in_ctrl[p2p_acr_pkg::CB_DIRECT]
      |=> out_route == p2p_acr_pkg::ROUTE_DIRECT)
      else $error("Translated request was not routed directly.");

   a_block_reports_viol: assert property (
      out_valid && (out_route == p2p_acr_pkg::ROUTE_BLOCKED)
      |-> viol_pulse && st.status[p2p_acr_pkg::ST_VIOL] &&
          (st.viol_info == {out_pkt.src, out_pkt.dst}))
      else $error("Blocked request did not record a violation.");

   a_block_over_redirect: assert property (
      in_valid && ACS_ON && (in_pkt.src != in_pkt.dst) && !is_cpl(in_pkt) &&
      !(is_xlat(in_pkt) && in_ctrl[p2p_acr_pkg::CB_DIRECT]) &&
      in_ctrl[p2p_acr_pkg::CB_EGR_EN] && egr_hit(st, in_pkt)
      |=> (out_route == p2p_acr_pkg::ROUTE_BLOCKED) &&
          (st.viol_info == {$past(in_pkt.src), $past(in_pkt.dst)}))
      else $error("Egress block lost against redirect.");

   a_viol_only_blocked: assert property (
      viol_pulse |-> out_valid && (out_route == p2p_acr_pkg::ROUTE_BLOCKED))
      else $error("Violation reported without a blocked request.");

   a_group_target_block: assert property (
      in_valid && ACS_ON && (in_pkt.src != in_pkt.dst) && !is_cpl(in_pkt) &&
      !(is_xlat(in_pkt) && in_ctrl[p2p_acr_pkg::CB_DIRECT]) &&
      in_ctrl[p2p_acr_pkg::CB_EGR_EN] && st.grp_en &&
      st.egr[in_pkt.src][st.grp[in_pkt.dst]]
      |=> out_route == p2p_acr_pkg::ROUTE_BLOCKED)
      else $error("Group egress block was not applied.");

   a_irq_follows_status: assert property (
      irq == |(st.status & st.mask))
      else $error("Interrupt does not match status and mask.");

   a_rdata_one_cycle: assert property (
      !$past(bus.rd) |-> rd_data == '0)
      else $error("Read data present without a read.");

   c_blocked: cover property (viol_pulse);
   c_req_up: cover property (out_valid && !is_cpl(out_pkt) &&
      (out_route == p2p_acr_pkg::ROUTE_UPSTREAM));
   c_cpl_up: cover property (out_valid && is_cpl(out_pkt) &&
      (out_route == p2p_acr_pkg::ROUTE_UPSTREAM));
   c_xlat_direct: cover property (out_valid && is_xlat(out_pkt) &&
      (out_route == p2p_acr_pkg::ROUTE_DIRECT));
   // A block decided through the function groups.
   c_group_block: cover property (viol_pulse && st.grp_en);

endmodule : p2p_access_control_router

`default_nettype wire

// ### tb/p2p_far_side.sv
`timescale 1ns/1ps
`default_nettype none

// Far side of the router: the upstream port and the peer functions.
// It takes every packet routed upstream or direct, and a blocked packet reaches neither of them.
module p2p_far_side (
   input  wire logic                clk,       // Link-layer clock.
   input  wire logic                rst_n,     // Asynchronous reset.
   input  wire logic                out_valid, // Decision present.
   input  wire p2p_acr_pkg::route_t out_route  // Routing decision.
);
   int n_up;   // Packets taken by the upstream port.
   int n_peer; // Packets taken by a peer function.

   // Counts each delivery once, in the only cycle in which it stands.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         n_up   <= 0;
         n_peer <= 0;
      end
      else if (out_valid && out_route == p2p_acr_pkg::ROUTE_UPSTREAM)
      begin
         n_up <= n_up + 1;
      end
      else if (out_valid && out_route == p2p_acr_pkg::ROUTE_DIRECT)
      begin
         n_peer <= n_peer + 1;
      end
   end
endmodule : p2p_far_side

`default_nettype wire

// ### tb/p2p_access_control_router_tb.sv
`timescale 1ns/1ps
`default_nettype none

module p2p_access_control_router_tb;
   localparam p2p_acr_pkg::kind_t  K_MR = p2p_acr_pkg::KIND_MEM_REQ;
   localparam p2p_acr_pkg::kind_t  K_OR = p2p_acr_pkg::KIND_OTHER_REQ;
   localparam p2p_acr_pkg::kind_t  K_RC = p2p_acr_pkg::KIND_RD_CPL;
   localparam p2p_acr_pkg::kind_t  K_OC = p2p_acr_pkg::KIND_OTHER_CPL;
   localparam p2p_acr_pkg::route_t R_D  = p2p_acr_pkg::ROUTE_DIRECT;
   localparam p2p_acr_pkg::route_t R_U  = p2p_acr_pkg::ROUTE_UPSTREAM;
   localparam p2p_acr_pkg::route_t R_B  = p2p_acr_pkg::ROUTE_BLOCKED;

   // One table row: sender controls, the packet, and the expected route.
   typedef struct packed {
      logic [3:0]          ctrl; // Control word of the sender.
      logic [7:0]          egr;  // Egress targets of the sender.
      p2p_acr_pkg::kind_t  kind; // Packet kind.
      logic [1:0]          at;   // Address type.
      logic                rel;  // Relaxed ordering.
      logic [2:0]          src;  // Sender.
      logic [2:0]          dst;  // Target.
      p2p_acr_pkg::route_t exp;  // Expected decision.
   } row_t;

   logic                  clk;        // Clock.
   logic                  rst_n;      // Reset, active low.
   p2p_acr_pkg::bus_req_t bus;        // Register port request.
   logic [31:0]           rd_data;    // Read data.
   logic                  in_valid;   // Packet present.
   p2p_acr_pkg::pkt_t     in_pkt;     // Packet header.
   logic                  out_valid;  // Decision present.
   p2p_acr_pkg::pkt_t     out_pkt;    // Decided header.
   p2p_acr_pkg::route_t   out_route;  // Decision.
   logic                  viol_pulse; // Violation pulse.
   logic                  irq;        // Interrupt level.
   int                    n_mismatch; // Mismatches seen.
   int                    compares;   // Comparisons made.
   int                    n_exp_up;   // Expected upstream deliveries.
   int                    n_exp_peer; // Expected peer deliveries.
   logic [31:0]           rd;         // Last read word.
   p2p_acr_pkg::pkt_t     p2;         // Second back-to-back packet.
   row_t                  rows [15];  // Ordinary cases.

   p2p_access_control_router DUT (.clk(clk), .rst_n(rst_n), .bus(bus), .rd_data(rd_data),
      .in_valid(in_valid), .in_pkt(in_pkt), .out_valid(out_valid), .out_pkt(out_pkt),
      .out_route(out_route), .viol_pulse(viol_pulse), .irq(irq));

   p2p_far_side far (.clk(clk), .rst_n(rst_n), .out_valid(out_valid), .out_route(out_route));

   // Free-running 250 MHz clock.
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Compares a decision.
   task automatic chk_route(input p2p_acr_pkg::route_t got, input p2p_acr_pkg::route_t exp);
      compares++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask : chk_route

   // Compares a word or a flag.
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask : chk_word

   // One-cycle register write, strobe dropped at the taking edge.
   task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      bus <= '0;
   endtask : bus_write

   // One-cycle register read; data is taken in the cycle after the taking edge.
   task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
      @(posedge clk);
      bus <= '0;
      #1;
      d = rd_data;
   endtask : bus_read

   // Checks the decision that stands one cycle after a packet was taken.
   task automatic check_pkt(input p2p_acr_pkg::pkt_t p, input p2p_acr_pkg::route_t exp);
      chk_route(out_route, exp);
      chk_word(32'(out_valid), 32'h1);
      chk_word(32'(viol_pulse), 32'(exp == R_B));
      chk_word(32'(out_pkt), 32'(p));
      if (exp == R_U) n_exp_up++;
      else if (exp == R_D) n_exp_peer++;
   endtask : check_pkt

   // Presents one packet for one cycle and checks its decision.
   task automatic send_pkt(input p2p_acr_pkg::pkt_t p, input p2p_acr_pkg::route_t exp);
      @(posedge clk);
      in_valid <= 1'b1;
      in_pkt   <= p;
      @(posedge clk);
      in_valid <= 1'b0;
      #1;
      check_pkt(p, exp);
   endtask : send_pkt

   // Ends the run with the verdict.
   task automatic final_report();
      if (n_mismatch == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : final_report

   // Cuts a hang short at 20000 cycles, far beyond the roughly 150 cycles the tests need.
   initial
   begin
      #(4 * 20000);
      n_mismatch++;
      final_report();
   end

   // Main sequence.
   initial
   begin
      rows = '{
         '{4'h0, 8'h00, K_MR, 2'h0, 1'b0, 3'h1, 3'h2, R_D},
         '{4'h1, 8'h00, K_MR, 2'h0, 1'b0, 3'h1, 3'h2, R_U},
         '{4'h1, 8'h00, K_RC, 2'h0, 1'b0, 3'h1, 3'h2, R_D},
         '{4'h2, 8'h00, K_RC, 2'h0, 1'b0, 3'h1, 3'h2, R_U},
         '{4'h2, 8'h00, K_RC, 2'h0, 1'b1, 3'h1, 3'h2, R_D},
         '{4'h2, 8'h00, K_OC, 2'h0, 1'b0, 3'h1, 3'h2, R_D},
         '{4'h2, 8'h00, K_MR, 2'h0, 1'b0, 3'h1, 3'h2, R_D},
         '{4'h8, 8'h04, K_MR, 2'h0, 1'b0, 3'h1, 3'h3, R_D},
         '{4'h9, 8'h04, K_OR, 2'h0, 1'b0, 3'h1, 3'h2, R_B},
         '{4'hD, 8'h04, K_MR, 2'h2, 1'b0, 3'h1, 3'h2, R_D},
         '{4'h5, 8'h00, K_MR, 2'h0, 1'b0, 3'h1, 3'h2, R_U},
         '{4'hD, 8'h04, K_RC, 2'h0, 1'b0, 3'h1, 3'h2, R_D},
         '{4'h1, 8'h00, K_MR, 2'h0, 1'b0, 3'h1, 3'h1, R_D},
         '{4'hD, 8'h04, K_OR, 2'h2, 1'b0, 3'h1, 3'h2, R_B},
         '{4'h8, 8'h04, K_MR, 2'h0, 1'b0, 3'h1, 3'h2, R_B}
      };
      rst_n    = 1'b0;
      bus      = '0;
      in_valid = 1'b0;
      in_pkt   = '0;
      repeat (10) @(posedge clk);
      chk_route(out_route, R_D);
      chk_word({30'h0, out_valid, irq}, 32'h0);
      rst_n <= 1'b1;
      bus_read(p2p_acr_pkg::CTRL_BASE, rd);
      chk_word(rd, 32'h0);
      // Table of ordinary cases; each row reprograms the sender first.
      foreach (rows[i])
      begin
         bus_write(p2p_acr_pkg::CTRL_BASE + {5'h00, rows[i].src}, {28'h0, rows[i].ctrl});
         bus_write(p2p_acr_pkg::EGR_BASE + {5'h00, rows[i].src}, {24'h0, rows[i].egr});
         send_pkt('{rows[i].kind, rows[i].at, rows[i].rel, rows[i].src, rows[i].dst,
                    16'hA500 + 16'(i)}, rows[i].exp);
      end
      // Register access: unused upper bits read 0, unmapped place reads 0.
      bus_write(p2p_acr_pkg::CTRL_BASE + 8'h03, 32'hFFFF_FFFF);
      bus_read(p2p_acr_pkg::CTRL_BASE + 8'h03, rd);
      chk_word(rd, 32'h0000_000F);
      bus_write(8'h1C, 32'hFFFF_FFFF);
      bus_read(8'h1C, rd);
      chk_word(rd, 32'h0);
      bus_read(p2p_acr_pkg::VIOL_OFS, rd);
      chk_word(rd, 32'h0000_000A);
      // Interrupt: sticky status, masked, then cleared by writing ones.
      bus_read(p2p_acr_pkg::STATUS_OFS, rd);
      chk_word(rd, 32'h0000_0007);
      chk_word(32'(irq), 32'h0);
      bus_write(p2p_acr_pkg::MASK_OFS, 32'h0000_0001);
      @(posedge clk);
      #1;
      chk_word(32'(irq), 32'h1);
      bus_write(p2p_acr_pkg::STATUS_OFS, 32'h0000_0001);
      @(posedge clk);
      #1;
      chk_word(32'(irq), 32'h0);
      bus_read(p2p_acr_pkg::STATUS_OFS, rd);
      chk_word(rd, 32'h0000_0006);
      // Group mode: function 3 sits in group 5, blocked by the sender's bit 5.
      bus_write(p2p_acr_pkg::GLOBAL_OFS, 32'h0000_0001);
      bus_write(p2p_acr_pkg::GRP_BASE + 8'h03, 32'h0000_0005);
      bus_write(p2p_acr_pkg::EGR_BASE + 8'h01, 32'h0000_0020);
      p2 = '{K_MR, 2'h0, 1'b0, 3'h1, 3'h5, 16'h5A5A};
      // Back-to-back packets with no gap.
      @(posedge clk);
      in_valid <= 1'b1;
      in_pkt   <= '{K_MR, 2'h0, 1'b0, 3'h1, 3'h3, 16'h1234};
      @(posedge clk);
      in_pkt <= p2;
      #1;
      check_pkt('{K_MR, 2'h0, 1'b0, 3'h1, 3'h3, 16'h1234}, R_B);
      @(posedge clk);
      in_valid <= 1'b0;
      #1;
      check_pkt(p2, R_D);
      @(posedge clk);
      #1;
      chk_word(32'(far.n_up), 32'(n_exp_up));
      chk_word(32'(far.n_peer), 32'(n_exp_peer));
      // Reset in mid-run: interrupt raised first, then everything must clear.
      bus_write(p2p_acr_pkg::MASK_OFS, 32'h0000_0007);
      @(posedge clk);
      #1;
      chk_word(32'(irq), 32'h1);
      @(posedge clk);
      rst_n <= 1'b0;
      @(posedge clk);
      #1;
      chk_word({29'h0, out_valid, viol_pulse, irq}, 32'h0);
      chk_word(32'(out_pkt), 32'h0);
      chk_route(out_route, R_D);
      @(posedge clk);
      rst_n <= 1'b1;
      bus_read(p2p_acr_pkg::STATUS_OFS, rd);
      chk_word(rd, 32'h0);
      bus_read(p2p_acr_pkg::CTRL_BASE + 8'h01, rd);
      chk_word(rd, 32'h0);
      bus_read(p2p_acr_pkg::GLOBAL_OFS, rd);
      chk_word(rd, 32'h0);
      send_pkt('{K_MR, 2'h0, 1'b0, 3'h1, 3'h3, 16'h0F0F}, R_D);
      final_report();
   end
endmodule : p2p_access_control_router_tb

`default_nettype wire
